//--- design/lom_top.sv
// loop output modulator: control demand, filter, action sense and output signals
`timescale 1ns/100ps
// How it works
// (RL1) integral term removes steady offset
// (RL2) derivative lowers output on rising process in reverse action
// (RL3) single output or heat/cool pair
// (RL4) heat/cool handover uses spread and demand
// (RL5) each output: relay drive or serial converter
// (RL6) on/off mode bypasses the demand arithmetic
// (RL7) cycle-ratio: on for percent of period
// (RL8) cycle period 1 to 255 seconds
// (RL9) line-cycle burst decides every line cycle
// (RL10) triple burst holds each decision three cycles
// (RL11) analog scales percent onto converter range
// (RL12) output filter 0 to 255 scans
// (RL13) full filter is 170/85/43 seconds
// (RL14) reverse action: output falls as process rises
// (RL15) direct action (single output only): output rises with process
// (RL16) operator picks starting gain band
// (RL17) on/off heat: on below band, off above setpoint
// (RL18) output linear inside gain band, saturated outside
// (RL19) algorithms act only in automatic mode
// (RL20) demand once per scan, clamped 0..100 (-100..100 for a heat/cool pair)
// (RL21) filter is first order, constant in scans
module lom_top
	import lom_pkg::*;
#(
	parameter int LOOPS = 16,
	parameter int SCAN_CYCLES = (LOOPS >= 16) ? SCAN16_CYCLES : (LOOPS >= 8) ? SCAN8_CYCLES : SCAN4_CYCLES,
	parameter int CSEC_LEN = CSEC_CYCLES
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic line_zc,
	output logic [1:0] out_pin,
	output logic dac_sclk,
	output logic dac_latch
);
	typedef struct packed {
		logic [CTL_W-1:0] ctrl;
		logic signed [15:0] setpt;
		logic signed [15:0] pv;
		logic [15:0] gain_band;
		logic [15:0] spread;
		logic [7:0] ki;
		logic [7:0] kd;
		logic [7:0] cycle;
		logic [7:0] filt;
		logic [6:0] manual;
		logic [15:0] rdata;
		logic [23:0] scan_cnt;
		logic [19:0] csec_cnt;
		logic [15:0] ratio_cnt;
		logic signed [15:0] pv_prev;
		logic signed [23:0] iacc;
		logic signed [15:0] filt_y;
		logic [1:0] onoff_on;
		logic cool_side;
		logic [6:0] pct_h;
		logic [6:0] pct_c;
		logic [1:0] pin;
		logic [1:0][DAC_BITS-1:0] dac_sh;
		logic [3:0] dac_bit;
		logic [2:0] dac_div;
		logic dac_busy;
		logic sclk;
		logic latch;
	} lom_state_t;

	lom_state_t s_r;
	lom_state_t s_nxt;
	logic [1:0] burst_fire;
	logic [1:0][1:0] mode_bits;

	assign mode_bits[0] = s_r.ctrl[CTL_HMODE +: 2];
	assign mode_bits[1] = s_r.ctrl[CTL_CMODE +: 2];

	function automatic logic signed [31:0] lom_clamp(input logic signed [31:0] v, input logic signed [31:0] lo,
		input logic signed [31:0] hi);
		lom_clamp = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_burst
			lom_burst_if bif ();
			assign bif.pct = (ch == 0) ? s_r.pct_h : s_r.pct_c;
			assign bif.zc = line_zc;
			assign bif.hold = (lom_omode_t'(mode_bits[ch]) == TRIPLE_CYCLE_BURST_OUTPUT) ? HOLD_TRIPLE : HOLD_SINGLE;
			assign burst_fire[ch] = bif.fire;
			lom_burst u_burst (
				.mclk(mclk),
				.rst_n(rst_n),
				.bp(bif.gen)
			);
		end
	endgenerate

	logic scan_tick;
	logic csec_tick;
	logic is_direct;
	logic is_pair;
	logic signed [31:0] sp32;
	logic signed [31:0] pv32;
	logic signed [31:0] err;
	logic signed [31:0] dpv;
	logic signed [31:0] bandv;
	logic signed [31:0] p;
	logic signed [31:0] iacc_v;
	logic signed [31:0] d;
	logic signed [31:0] u;
	logic signed [31:0] x8;
	logic signed [31:0] y;
	logic signed [31:0] yf;
	logic [15:0] ratio_len;
	logic [6:0] pct;
	logic [15:0] on_len;
	lom_omode_t om;

	always_comb begin
		s_nxt = s_r;
		pct = '0;
		on_len = '0;
		om = CYCLE_RATIO_OUTPUT;
		is_direct = s_r.ctrl[CTL_DIRECT];
		is_pair = s_r.ctrl[CTL_PAIR];
		scan_tick = (s_r.scan_cnt == 24'(SCAN_CYCLES - 1));
		csec_tick = (s_r.csec_cnt == 20'(CSEC_LEN - 1));
		sp32 = 32'(s_r.setpt);
		pv32 = 32'(s_r.pv);
		// a paired loop always computes in the heating sense; cooling is the negative demand
		err = (is_direct && !is_pair) ? pv32 - sp32 : sp32 - pv32; // RL14 RL15
		dpv = (is_direct && !is_pair) ? pv32 - 32'(s_r.pv_prev) : 32'(s_r.pv_prev) - pv32; // RL2
		bandv = (s_r.gain_band == 16'h0000) ? 32'sd1 : $signed({16'h0000, s_r.gain_band});
		p = lom_clamp(err * PCT_FULL / bandv, -PCT_FULL, PCT_FULL); // RL18
		iacc_v = lom_clamp(32'(s_r.iacc) + p * $signed({24'h000000, s_r.ki}), -ILIM, ILIM); // RL1
		d = dpv * $signed({24'h000000, s_r.kd}) * PCT_FULL / bandv; // RL2
		u = lom_clamp(p + (s_r.ctrl[CTL_INT] ? (iacc_v >>> PCT_SCALE) : 32'sd0)
			+ (s_r.ctrl[CTL_DER] ? d : 32'sd0), is_pair ? -PCT_FULL : 32'sd0, PCT_FULL); // RL20
		x8 = u <<< PCT_SCALE;
		y = 32'(s_r.filt_y);
		// filter setting zero passes the demand straight through
		y = (s_r.filt == 8'h00) ? x8 : y + (x8 - y) / $signed({24'h000000, s_r.filt}); // RL12 RL21 RL13
		yf = y >>> PCT_SCALE;
		ratio_len = 16'((s_r.cycle < CYCLE_MIN) ? CYCLE_MIN : s_r.cycle) * 16'(CSEC_PER_S); // RL8

		// time bases
		s_nxt.scan_cnt = scan_tick ? 24'h000000 : s_r.scan_cnt + 24'h000001;
		s_nxt.csec_cnt = csec_tick ? 20'h00000 : s_r.csec_cnt + 20'h00001;
		if (csec_tick) begin
			s_nxt.ratio_cnt = (s_r.ratio_cnt >= ratio_len - 16'h0001) ? 16'h0000 : s_r.ratio_cnt + 16'h0001; // RL7
		end

		// once per scan: new demand for both outputs
		if (scan_tick) begin
			s_nxt.pv_prev = s_r.pv;
			if (!s_r.ctrl[CTL_AUTO]) begin
				// manual: loop arithmetic frozen, operator value drives the output
				s_nxt.pct_h = s_r.manual; // RL19
				s_nxt.pct_c = 7'h00;
			end else if (s_r.ctrl[CTL_ONOFF]) begin
				// heat side: on below setpoint minus spread, off above setpoint
				if (pv32 < sp32 - 32'(s_r.spread)) begin
					s_nxt.onoff_on[0] = !(is_direct && !is_pair); // RL17
				end else if (pv32 > sp32) begin
					s_nxt.onoff_on[0] = is_direct && !is_pair;
				end
				// cooling mirrors it about setpoint
				if (pv32 > sp32 + 32'(s_r.spread)) begin
					s_nxt.onoff_on[1] = 1'b1;
				end else if (pv32 < sp32) begin
					s_nxt.onoff_on[1] = 1'b0;
				end
				if (is_direct && !is_pair) begin
					s_nxt.onoff_on[0] = s_nxt.onoff_on[1];
				end
				s_nxt.pct_h = s_nxt.onoff_on[0] ? 7'(PCT_FULL) : 7'h00; // RL6
				s_nxt.pct_c = (is_pair && s_nxt.onoff_on[1]) ? 7'(PCT_FULL) : 7'h00; // RL3
			end else begin
				s_nxt.iacc = 24'(iacc_v);
				s_nxt.filt_y = 16'(y);
				// handover needs the process past the spread as well as a demand of the other sign
				if (!s_r.cool_side && yf < 0 && pv32 > sp32 + 32'(s_r.spread)) begin
					s_nxt.cool_side = 1'b1; // RL4
				end else if (s_r.cool_side && yf > 0 && pv32 < sp32 - 32'(s_r.spread)) begin
					s_nxt.cool_side = 1'b0; // RL4
				end
				if (!is_pair) begin
					s_nxt.cool_side = 1'b0;
				end
				s_nxt.pct_h = (!s_nxt.cool_side && yf > 0) ? 7'(yf) : 7'h00; // RL3
				s_nxt.pct_c = (is_pair && s_nxt.cool_side && yf < 0) ? 7'(-yf) : 7'h00;
			end
			// converter words load on the scan and are shifted out serially
			for (int c = 0; c < 2; c++) begin
				pct = (c == 0) ? s_nxt.pct_h : s_nxt.pct_c;
				s_nxt.dac_sh[c] = DAC_BITS'(32'(pct) * DAC_FULL / PCT_FULL); // RL11
			end
			s_nxt.dac_busy = 1'b1;
			s_nxt.dac_bit = 4'h0;
			s_nxt.dac_div = 3'h0;
			s_nxt.sclk = 1'b0;
		end

		// serial converter shifter: data set while clock low, sampled on its rise
		s_nxt.latch = 1'b0;
		if (s_r.dac_busy && !scan_tick) begin
			s_nxt.dac_div = s_r.dac_div + 3'h1;
			if (s_r.dac_div == DAC_DIV_LAST) begin
				s_nxt.sclk = !s_r.sclk;
				if (s_r.sclk) begin
					s_nxt.dac_sh[0] = {s_r.dac_sh[0][DAC_BITS-2:0], 1'b0};
					s_nxt.dac_sh[1] = {s_r.dac_sh[1][DAC_BITS-2:0], 1'b0};
					s_nxt.dac_bit = s_r.dac_bit + 4'h1;
					if (s_r.dac_bit == DAC_BIT_LAST) begin
						s_nxt.dac_busy = 1'b0;
						s_nxt.latch = 1'b1;
					end
				end
			end
		end

		// pin drive per output according to its signal mode
		for (int c = 0; c < 2; c++) begin
			om = lom_omode_t'(c == 0 ? s_r.ctrl[CTL_HMODE +: 2] : s_r.ctrl[CTL_CMODE +: 2]);
			pct = (c == 0) ? s_r.pct_h : s_r.pct_c;
			on_len = 16'(pct) * 16'((s_r.cycle < CYCLE_MIN) ? CYCLE_MIN : s_r.cycle);
			case (om)
				CYCLE_RATIO_OUTPUT: s_nxt.pin[c] = s_r.ratio_cnt < on_len; // RL7
				LINE_CYCLE_BURST_OUTPUT: s_nxt.pin[c] = burst_fire[c]; // RL9
				TRIPLE_CYCLE_BURST_OUTPUT: s_nxt.pin[c] = burst_fire[c]; // RL10
				ANALOG_OUTPUT: s_nxt.pin[c] = s_r.dac_busy & s_r.dac_sh[c][DAC_BITS-1]; // RL5
				default: s_nxt.pin[c] = 1'b0;
			endcase
		end

		// register port
		s_nxt.rdata = 16'h0000;
		if (wr) begin
			case (addr)
				REG_CTRL: s_nxt.ctrl = wdata[CTL_W-1:0];
				REG_SETPT: s_nxt.setpt = wdata;
				REG_PV: s_nxt.pv = wdata;
				REG_GAIN_BAND: s_nxt.gain_band = wdata;
				REG_SPREAD: s_nxt.spread = wdata;
				REG_KI: s_nxt.ki = wdata[7:0];
				REG_KD: s_nxt.kd = wdata[7:0];
				REG_CYCLE: s_nxt.cycle = wdata[7:0];
				REG_FILTER: s_nxt.filt = wdata[7:0];
				REG_MANUAL: s_nxt.manual = (wdata > 16'(PCT_FULL)) ? 7'(PCT_FULL) : wdata[6:0];
				default: s_nxt.ctrl = s_nxt.ctrl;
			endcase
		end else if (rd) begin
			case (addr)
				REG_CTRL: s_nxt.rdata = 16'(s_r.ctrl);
				REG_SETPT: s_nxt.rdata = s_r.setpt;
				REG_PV: s_nxt.rdata = s_r.pv;
				REG_GAIN_BAND: s_nxt.rdata = s_r.gain_band;
				REG_SPREAD: s_nxt.rdata = s_r.spread;
				REG_KI: s_nxt.rdata = 16'(s_r.ki);
				REG_KD: s_nxt.rdata = 16'(s_r.kd);
				REG_CYCLE: s_nxt.rdata = 16'(s_r.cycle);
				REG_FILTER: s_nxt.rdata = 16'(s_r.filt);
				REG_MANUAL: s_nxt.rdata = 16'(s_r.manual);
				REG_STATUS: begin
					s_nxt.rdata[ST_PCT_H +: 7] = s_r.pct_h;
					s_nxt.rdata[ST_PCT_C +: 7] = s_r.pct_c;
					s_nxt.rdata[ST_COOL] = s_r.cool_side;
					s_nxt.rdata[ST_AUTO] = s_r.ctrl[CTL_AUTO];
				end
				default: s_nxt.rdata = 16'h0000;
			endcase
		end

		if (!rst_n) begin
			s_nxt = '0;
			s_nxt.ctrl = CTRL_RST;
			s_nxt.gain_band = GAIN_BAND_RST;
			s_nxt.spread = SPREAD_RST;
			s_nxt.cycle = CYCLE_RST;
		end
	end

	always_ff @(posedge mclk) begin
		s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
	assign out_pin = s_r.pin;
	assign dac_sclk = s_r.sclk;
	assign dac_latch = s_r.latch;
endmodule

//--- include/lom_pkg.sv
// constants and types shared by the loop output modulator files
package lom_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	// filter time constant at the largest setting, per controller loop count
	localparam int FILT_MAX = 255;
	localparam int FILT_TC16_MS = 170_000;
	localparam int FILT_TC8_MS = 85_000;
	localparam int FILT_TC4_MS = 43_000;
	localparam int SCAN16_CYCLES = FILT_TC16_MS * CLK_PER_MS / FILT_MAX;
	localparam int SCAN8_CYCLES = FILT_TC8_MS * CLK_PER_MS / FILT_MAX;
	localparam int SCAN4_CYCLES = FILT_TC4_MS * CLK_PER_MS / FILT_MAX;
	// cycle-ratio output time base: one step per hundredth of a second
	localparam int CSEC_MS = 10;
	localparam int CSEC_CYCLES = CSEC_MS * CLK_PER_MS;
	localparam int CSEC_PER_S = 100;
	localparam int PCT_FULL = 100;
	localparam int PCT_SCALE = 8;
	localparam int ILIM = PCT_FULL << PCT_SCALE;
	localparam logic [7:0] CYCLE_MIN = 8'h01;
	// serial converter link
	localparam int DAC_BITS = 12;
	localparam int DAC_FULL = (1 << DAC_BITS) - 1;
	localparam logic [2:0] DAC_DIV_LAST = 3'h7;
	localparam logic [3:0] DAC_BIT_LAST = 4'(DAC_BITS - 1);
	// register byte addresses
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_SETPT = 6'h04;
	localparam logic [5:0] REG_PV = 6'h08;
	localparam logic [5:0] REG_GAIN_BAND = 6'h0C;
	localparam logic [5:0] REG_SPREAD = 6'h10;
	localparam logic [5:0] REG_KI = 6'h14;
	localparam logic [5:0] REG_KD = 6'h18;
	localparam logic [5:0] REG_CYCLE = 6'h1C;
	localparam logic [5:0] REG_FILTER = 6'h20;
	localparam logic [5:0] REG_MANUAL = 6'h24;
	localparam logic [5:0] REG_STATUS = 6'h28;
	// control register fields
	localparam int CTL_AUTO = 0;
	localparam int CTL_DIRECT = 1;
	localparam int CTL_INT = 2;
	localparam int CTL_DER = 3;
	localparam int CTL_ONOFF = 4;
	localparam int CTL_PAIR = 5;
	localparam int CTL_HMODE = 6;
	localparam int CTL_CMODE = 8;
	localparam int CTL_W = 10;
	// status register fields
	localparam int ST_PCT_H = 0;
	localparam int ST_PCT_C = 7;
	localparam int ST_COOL = 14;
	localparam int ST_AUTO = 15;
	// values after reset
	localparam logic [CTL_W-1:0] CTRL_RST = 10'h000;
	localparam logic [15:0] GAIN_BAND_RST = 16'h0014;
	localparam logic [15:0] SPREAD_RST = 16'h0014;
	localparam logic [7:0] CYCLE_RST = 8'h01;
	localparam logic [1:0] HOLD_SINGLE = 2'h1;
	localparam logic [1:0] HOLD_TRIPLE = 2'h3;
	typedef enum logic [1:0] {
		CYCLE_RATIO_OUTPUT,
		LINE_CYCLE_BURST_OUTPUT,
		TRIPLE_CYCLE_BURST_OUTPUT,
		ANALOG_OUTPUT
	} lom_omode_t;
endpackage

//--- include/lom_burst_if.sv
// link between the modulator core and one line-cycle burst generator
`timescale 1ns/100ps
interface lom_burst_if;
	logic [6:0] pct;
	logic zc;
	logic [1:0] hold;
	logic fire;
	modport gen (input pct, input zc, input hold, output fire);
	modport ctl (output pct, output zc, output hold, input fire);
endinterface

//--- design/lom_burst.sv
// per-line-cycle burst generator with a minimum hold in line cycles
`timescale 1ns/100ps
module lom_burst
	import lom_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	lom_burst_if.gen bp
);
	typedef struct packed {
		logic [7:0] acc;
		logic [1:0] left;
		logic fire;
	} lom_burst_st_t;

	lom_burst_st_t s_r;
	lom_burst_st_t s_nxt;
	logic [7:0] sum;

	always_comb begin
		s_nxt = s_r;
		sum = s_r.acc + 8'(bp.pct);
		if (bp.zc) begin
			if (s_r.left <= 2'h1) begin
				// error diffusion spreads the on cycles evenly over time
				if (sum >= 8'(PCT_FULL)) begin // RL9
					s_nxt.fire = 1'b1;
					s_nxt.acc = sum - 8'(PCT_FULL);
				end else begin
					s_nxt.fire = 1'b0;
					s_nxt.acc = sum;
				end
				s_nxt.left = bp.hold; // RL10
			end else begin
				s_nxt.left = s_r.left - 2'h1;
			end
		end
		if (!rst_n) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		s_r <= s_nxt;
	end

	assign bp.fire = s_r.fire;
endmodule

//--- dv/lom_dac_model.sv
// behavioural serial converter pair fed from the two open collector pins
`timescale 1ns/100ps
module lom_dac_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic dac_sclk,
	input wire logic dac_latch,
	input wire logic [1:0] din,
	output logic [11:0] word0,
	output logic [11:0] word1
);
	logic [11:0] sh0_r, sh1_r;
	logic sclk_r;
	// bits are taken one clock after sclk rises, inside the stable data window
	always_ff @(posedge mclk) begin
		sclk_r <= dac_sclk;
		if (!rst_n) begin
			word0 <= 12'h000;
			word1 <= 12'h000;
		end else begin
			if (dac_sclk && !sclk_r) begin
				sh0_r <= {sh0_r[10:0], din[0]};
				sh1_r <= {sh1_r[10:0], din[1]};
			end
			if (dac_latch) begin
				word0 <= sh0_r;
				word1 <= sh1_r;
			end
		end
	end
endmodule

//--- dv/lom_checker.sv
// pin-level checks of the loop output modulator, bound to its top module
`timescale 1ns/100ps
module lom_checker
	import lom_pkg::*;
#(
	parameter int SCAN_CYCLES = 400
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic line_zc,
	input wire logic [1:0] out_pin,
	input wire logic dac_sclk,
	input wire logic dac_latch
);
	logic [9:0] ctl_r;
	logic [15:0] sp_r, pv_r, spr_r, man_r, age_r;
	logic calm;
	// any write restarts the age: pins are judged once a full scan has passed, the burst pin after four cycles
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctl_r <= CTRL_RST;
			sp_r <= 16'h0000;
			pv_r <= 16'h0000;
			spr_r <= SPREAD_RST;
			man_r <= 16'h0000;
			age_r <= 16'h0000;
		end else begin
			age_r <= wr ? 16'h0000 : age_r + 16'(age_r != 16'hFFFF);
			if (wr && addr == REG_CTRL) ctl_r <= wdata[9:0];
			if (wr && addr == REG_SETPT) sp_r <= wdata;
			if (wr && addr == REG_PV) pv_r <= wdata;
			if (wr && addr == REG_SPREAD) spr_r <= wdata;
			if (wr && addr == REG_MANUAL) man_r <= wdata;
		end
	end
	assign calm = 32'(age_r) > SCAN_CYCLES + 4;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence sclk_half_s;
		dac_sclk [*8] ##1 !dac_sclk;
	endsequence
	man_off_a: assert property (calm && (ctl_r & 10'h0C1) == 10'h000 && man_r == 16'h0000 |-> !out_pin[0])
		else $error("heat pin on at zero manual");
	man_full_a: assert property (calm && (ctl_r & 10'h0C1) == 10'h000 && man_r >= 16'h0064 |-> out_pin[0])
		else $error("heat pin off at full manual");
	single_cool_a: assert property (calm && !ctl_r[5] |-> !out_pin[1])
		else $error("cool pin on in single mode");
	onoff_on_a: assert property (calm && (ctl_r & 10'h0D3) == 10'h011 &&
		$signed(pv_r) < $signed(sp_r) - $signed(spr_r) |-> out_pin[0])
		else $error("on/off heat not on below band");
	onoff_off_a: assert property (calm && (ctl_r & 10'h0D3) == 10'h011 && $signed(pv_r) > $signed(sp_r) |-> !out_pin[0])
		else $error("on/off heat not off above setpoint");
	burst_edge_a: assert property (ctl_r[7:6] == 2'h1 && age_r > 16'h0004 && $changed(out_pin[0]) |-> $past(line_zc, 2))
		else $error("burst pin moved away from a line cycle");
	sclk_half_a: assert property ($rose(dac_sclk) |-> sclk_half_s)
		else $error("converter clock high phase wrong");
	latch_one_a: assert property (dac_latch |=> !dac_latch)
		else $error("latch longer than one cycle");
endmodule
bind lom_top lom_checker #(.SCAN_CYCLES(SCAN_CYCLES)) i_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .line_zc(line_zc), .out_pin(out_pin),
	.dac_sclk(dac_sclk), .dac_latch(dac_latch));

//--- dv/tb.sv
// self-checking bench for the loop output modulator
`timescale 1ns/100ps
module tb
	import lom_pkg::*;
;
	localparam int SCAN = 400;
	localparam int CSL = 4;
	logic mclk, rst_n, wr, rd, line_zc, hit, last;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, d;
	logic [1:0] out_pin;
	logic dac_sclk, dac_latch;
	logic [11:0] w0, w1;
	logic [6:0] mn;
	int n_errors, total_checks, cnt;
	// rows 0..6 proportional, 7..11 on/off with spread, 12..15 heat/cool pair
	logic [15:0] pv_tab[16] = '{16'h03DE, 16'h03D9, 16'h03E8, 16'h03F2, 16'h03CA, 16'h03F2, 16'h03DE, 16'h03D3,
		16'h03DE, 16'h03E9, 16'h03DE, 16'h03D3, 16'h0406, 16'h03F2, 16'h03DE, 16'h03CA};
	logic [6:0] te[16] = '{7'h32, 7'h4B, 7'h00, 7'h00, 7'h64, 7'h32, 7'h00, 7'h01,
		7'h01, 7'h00, 7'h00, 7'h01, 7'h01, 7'h01, 7'h01, 7'h00};
	lom_top #(.SCAN_CYCLES(SCAN), .CSEC_LEN(CSL)) i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .line_zc(line_zc), .out_pin(out_pin), .dac_sclk(dac_sclk),
		.dac_latch(dac_latch));
	lom_dac_model i_dac (.mclk(mclk), .rst_n(rst_n), .dac_sclk(dac_sclk), .dac_latch(dac_latch),
		.din(out_pin), .word0(w0), .word1(w1));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wreg(input logic [5:0] a, input logic [15:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so it is taken mid-cycle
	task rreg(input logic [5:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask
	task scans(input int n);
		repeat (n * SCAN) @(posedge mclk);
	endtask
	task run(input logic [15:0] c, input logic [15:0] p);
		wreg(REG_CTRL, c);
		wreg(REG_PV, p);
		scans(2);
		rreg(REG_STATUS);
	endtask
	// scan tick phase is unknown, so the status is polled over more than one scan
	task sweep(input logic [6:0] v);
		mn = 7'h7F;
		hit = 1'b0;
		repeat (400) begin
			rreg(REG_STATUS);
			if (d[6:0] < mn) mn = d[6:0];
			if (d[6:0] === v) hit = 1'b1;
		end
	endtask
	task hi(input int n);
		cnt = 0;
		repeat (n) begin
			@(negedge mclk);
			cnt += int'(out_pin[0] === 1'b1);
		end
	endtask
	task zc();
		@(posedge mclk);
		line_zc <= 1'b1;
		@(posedge mclk);
		line_zc <= 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		line_zc = 1'b0;
		addr = 6'h00;
		wdata = 16'h0000;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rreg(REG_CTRL);
		cmp("ctrl reset", 16'h0000, d);
		rreg(REG_GAIN_BAND);
		cmp("band reset", 16'h0014, d);
		wreg(REG_MANUAL, 16'h0096);
		rreg(REG_MANUAL);
		cmp("manual clamp", 16'h0064, d);
		wreg(REG_SETPT, 16'h03E8);
		wreg(REG_PV, 16'h03DE);
		wreg(REG_MANUAL, 16'h001E);
		scans(2);
		rreg(REG_STATUS);
		cmp("manual pct", 16'h001E, {9'h000, d[6:0]});
		hi(100 * CSL);
		cmp("ratio on", 16'(30 * CSL), 16'(cnt));
		wreg(REG_CYCLE, 16'h00FF);
		rreg(REG_CYCLE);
		cmp("cycle max", 16'h00FF, d);
		wreg(REG_CYCLE, 16'h0002);
		scans(2);
		hi(200 * CSL);
		cmp("ratio on 2s", 16'(60 * CSL), 16'(cnt));
		wreg(REG_CYCLE, 16'h0001);
		for (int i = 0; i < 16; i++) begin
			run(i < 5 ? 16'h0001 : i < 7 ? 16'h0003 : i < 12 ? 16'h0011 : 16'h0021, pv_tab[i]);
			if (i < 7) cmp("pct", {9'h000, te[i]}, {9'h000, d[6:0]});
			else if (i < 12) cmp("onoff pin", {9'h000, te[i]}, {15'h0000, out_pin[0]});
			else cmp("cool side", {9'h000, te[i]}, {15'h0000, d[14]});
		end
		wreg(REG_KD, 16'h0001);
		run(16'h0009, 16'h03D4);
		wreg(REG_PV, 16'h03DE);
		sweep(7'h00);
		cmp("deriv dip", 16'h0001, 16'(mn < 7'h32));
		wreg(REG_KD, 16'h0000);
		run(16'h0001, 16'h03E8);
		wreg(REG_FILTER, 16'h0002);
		wreg(REG_PV, 16'h03D4);
		sweep(7'h32);
		cmp("filter step", 16'h0001, 16'(hit));
		wreg(REG_FILTER, 16'h0000);
		wreg(REG_KI, 16'h00FF);
		run(16'h0005, 16'h03E3);
		cmp("integral rise", 16'h0001, 16'(d[6:0] > 7'h19));
		wreg(REG_KI, 16'h0000);
		wreg(REG_CTRL, 16'h0040);
		wreg(REG_MANUAL, 16'h0032);
		scans(2);
		cnt = 0;
		repeat (10) begin
			zc();
			cnt += int'(out_pin[0] === 1'b1);
		end
		cmp("burst count", 16'h0005, 16'(cnt));
		wreg(REG_CTRL, 16'h0080);
		zc();
		last = out_pin[0];
		cnt = 0;
		repeat (11) begin
			zc();
			cnt += int'(out_pin[0] !== last);
			last = out_pin[0];
		end
		cmp("triple toggles", 16'h0001, 16'(cnt >= 1 && cnt <= 4));
		wreg(REG_CTRL, 16'h03C0);
		wreg(REG_MANUAL, 16'h0064);
		scans(2);
		cmp("dac full", 16'h0FFF, {4'h0, w0});
		cmp("dac cool", 16'h0000, {4'h0, w1});
		wreg(REG_MANUAL, 16'h0032);
		scans(2);
		cmp("dac half", 16'h07FF, {4'h0, w0});
		finish_test();
	end
endmodule
